// >>> hw/hbd_half_bridge_drive_and_chopper.sv
// independent half-bridge drive with fixed off-time mixed-decay chopping
`timescale 1ns/100ps
module hbd_half_bridge_drive_and_chopper #(
    parameter int HOLD_CYC = hbd_pkg::CHOP_HOLD_CYC,
    parameter int MASK_CYC = hbd_pkg::SENSE_MASK_CYC
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // host control pins, asynchronous
    input wire logic ctl_a_sel_in,
    input wire logic ctl_b_sel_in,
    input wire logic ctl_c_sel_in,
    input wire logic ctl_d_sel_in,
    input wire logic low_power_request_n_in,
    input wire logic current_halving_sel_in,
    // sense comparators, one per pair, asynchronous
    input wire logic sense_trip_ab_in,
    input wire logic sense_trip_cd_in,
    // reference select to the analog comparators
    output logic chop_ref_half_out,
    // gate controls per half-bridge, bit 0 = a .. bit 3 = d
    output logic [3:0] high_side_on_out,
    output logic [3:0] low_side_on_out,
    // pair chopping status
    output logic [1:0] pair_off_out
);
    import hbd_pkg::*;

    // fast decay covers the first quarter of the hold, rounded down;
    // the hold floor below keeps it at one cycle or more, so the
    // slow part always follows a real fast part
    localparam int FAST_CYC = (HOLD_CYC * FAST_DECAY_NUM) / DECAY_DEN;

    // positions of the pins in the sampled vector; the order
    // matches the concatenation into raw_sig below
    localparam int PIN_W = 8;
    localparam int PIN_CTL = 0;
    localparam int PIN_AWAKE = 4;
    localparam int PIN_HALF = 5;
    localparam int PIN_TRIP = 6;

    // refuse counts that the shared timer cannot serve
    if (HOLD_CYC < 4 || HOLD_CYC >= (1 << TIMER_W) ||
        MASK_CYC < 1 || MASK_CYC >= (1 << TIMER_W)) begin : g_bad_counts
        $error("hbd: timer counts out of range");
    end

    // three-stage synchronisers for all pins; the pins are
    // asynchronous to clk_in, so no logic reads the first stage,
    // and a level counts only once two later stages show it
    logic [PIN_W-1:0] raw_sig;
    logic [PIN_W-1:0] sync1_reg;
    logic [PIN_W-1:0] sync2_reg;
    logic [PIN_W-1:0] sync3_reg;
    logic [PIN_W-1:0] pin_reg;
    assign raw_sig = {sense_trip_cd_in, sense_trip_ab_in,
                      current_halving_sel_in, low_power_request_n_in,
                      ctl_d_sel_in, ctl_c_sel_in, ctl_b_sel_in, ctl_a_sel_in};

    // sample chain
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
        end else begin
            sync1_reg <= raw_sig;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // accept a change once stages two and three agree;
    // a one-cycle glitch on a pin never reaches the logic
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pin_reg <= '0;
        end else begin
            for (int i = 0; i < PIN_W; i++) begin
                if (sync2_reg[i] == sync3_reg[i]) begin
                    pin_reg[i] <= sync3_reg[i];
                end
            end
        end
    end

    // agreed pin levels by role
    logic [3:0] ctl_sel;
    logic awake;
    logic [1:0] trip;
    assign ctl_sel = pin_reg[PIN_CTL +: 4];
    assign awake = pin_reg[PIN_AWAKE];
    assign trip = pin_reg[PIN_TRIP +: 2];

    // reference select for the trip comparators;
    // registered so the comparators see a clean level
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            chop_ref_half_out <= REF_FULL;
        end else begin
            chop_ref_half_out <= pin_reg[PIN_HALF] ? REF_HALF
                                                   : REF_FULL;
        end
    end

    // per-pair chopping state and timers; each sense node serves
    // one pair, so the pairs never share a timer
    hbd_phase_t phase_reg [2];
    logic [TIMER_W-1:0] tmr_reg [2];

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int p = 0; p < 2; p++) begin
                phase_reg[p] <= HBD_BLANK;
                tmr_reg[p] <= '0;
            end
        end else begin
            for (int p = 0; p < 2; p++) begin
                // sleep clears both pairs, so a wake starts with a mask
                if (!awake) begin
                    phase_reg[p] <= HBD_BLANK;
                    tmr_reg[p] <= '0;
                end else begin
                    // one timer per pair: the mask count, then the
                    // hold count that also times the decay split
                    unique case (phase_reg[p])
                        HBD_BLANK: begin
                            // comparator ignored while masking
                            if (tmr_reg[p] == TIMER_W'(MASK_CYC - 1)) begin
                                phase_reg[p] <= HBD_SENSE;
                                tmr_reg[p] <= '0;
                            end else begin
                                tmr_reg[p] <= tmr_reg[p] + TIMER_W'(1);
                            end
                        end
                        HBD_SENSE: begin
                            // a trip still high here starts a new hold
                            if (trip[p]) begin
                                phase_reg[p] <= HBD_FAST;
                                tmr_reg[p] <= '0;
                            end
                        end
                        HBD_FAST: begin
                            // timer runs on so the hold stays fixed
                            if (tmr_reg[p] == TIMER_W'(FAST_CYC - 1)) begin
                                phase_reg[p] <= HBD_SLOW;
                            end
                            tmr_reg[p] <= tmr_reg[p] + TIMER_W'(1);
                        end
                        HBD_SLOW: begin
                            if (tmr_reg[p] == TIMER_W'(HOLD_CYC - 1)) begin
                                phase_reg[p] <= HBD_BLANK;
                                tmr_reg[p] <= '0;
                            end else begin
                                tmr_reg[p] <= tmr_reg[p] + TIMER_W'(1);
                            end
                        end
                    endcase
                end
            end
        end
    end

    // gate drive: sleep off, chop by pair, else follow inputs;
    // a high side and its low side are never on together, so a
    // bridge cannot short the supply whatever the inputs do;
    // all off lets the diodes carry the fast decay current
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            high_side_on_out <= 4'h0;
            low_side_on_out <= 4'h0;
        end else begin
            for (int h = 0; h < 4; h++) begin
                if (!awake) begin
                    high_side_on_out[h] <= 1'b0;
                    low_side_on_out[h] <= 1'b0;
                end else if (phase_reg[h/2] == HBD_FAST) begin
                    high_side_on_out[h] <= 1'b0;
                    low_side_on_out[h] <= 1'b0;
                end else if (phase_reg[h/2] == HBD_SLOW) begin
                    high_side_on_out[h] <= 1'b0;
                    low_side_on_out[h] <= 1'b1;
                end else begin
                    high_side_on_out[h] <= ctl_sel[h];
                    low_side_on_out[h] <= !ctl_sel[h];
                end
            end
        end
    end

    // pair status: high through the whole hold, fast and slow alike;
    // it leads no gate, it only reports the chopping to the host
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pair_off_out <= 2'b00;
        end else begin
            for (int p = 0; p < 2; p++) begin
                pair_off_out[p] <= awake && (phase_reg[p] == HBD_FAST ||
                                             phase_reg[p] == HBD_SLOW);
            end
        end
    end
endmodule // hbd_half_bridge_drive_and_chopper

// >>> hw/hbd_pkg.sv
// constants for the half-bridge drive and chopper block
package hbd_pkg;
    // time figures in ns and the clock period
    localparam int CLK_PERIOD_NS = 10;
    localparam int CHOP_HOLD_TIME_NS = 20000;
    localparam int SENSE_MASK_TIME_NS = 1000;
    // cycle counts derived from the times (hold rounds down, mask rounds up)
    localparam int CHOP_HOLD_CYC = CHOP_HOLD_TIME_NS / CLK_PERIOD_NS;
    localparam int SENSE_MASK_CYC =
        (SENSE_MASK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // mixed decay split: fast part is one quarter of the hold
    localparam int FAST_DECAY_NUM = 25;
    localparam int DECAY_DEN = 100;
    localparam int TIMER_W = 16;
    // reference select codes
    localparam logic REF_FULL = 1'b0;
    localparam logic REF_HALF = 1'b1;
    // per-pair chopping phase
    typedef enum logic [1:0] {
        HBD_BLANK, HBD_SENSE, HBD_FAST, HBD_SLOW
    } hbd_phase_t;
endpackage

// >>> verif/hbd_chopper_checker.sv
// port assertions for the half-bridge drive and chopper
`timescale 1ns/100ps
module hbd_chopper_checker #(
    parameter int HOLD_CYC = 8,
    parameter int MASK_CYC = 2
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // host pins
    input wire logic ctl_a_sel_in,
    input wire logic low_power_request_n_in,
    input wire logic current_halving_sel_in,
    // gate and status outputs
    input wire logic chop_ref_half_out,
    input wire logic [3:0] high_side_on_out,
    input wire logic [3:0] low_side_on_out,
    input wire logic [1:0] pair_off_out
);
    localparam int FAST_CYC = HOLD_CYC * 25 / 100;
    localparam int HOLD_M1 = HOLD_CYC - 1;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    // sleep, switch and reference relations
    chk_sleep_all_off: assert property (
        !low_power_request_n_in [*6] |-> low_side_on_out == 4'h0
        && high_side_on_out == 4'h0) else $error("gates on in sleep");
    chk_no_shoot: assert property (
        (high_side_on_out & low_side_on_out) == 4'h0) else $error("shoot");
    chk_ref_half: assert property (
        current_halving_sel_in [*6] |-> chop_ref_half_out) else $error("ref");
    chk_ref_full: assert property (
        !current_halving_sel_in [*6] |-> !chop_ref_half_out) else $error("ref");
    chk_follow_ctl: assert property (
        (low_power_request_n_in && ctl_a_sel_in && !pair_off_out[0]) [*6]
        |-> high_side_on_out[0]) else $error("bridge a not driven high");
    // chopping relations
    chk_pair_gates: assert property (
        pair_off_out[1] |-> high_side_on_out[3:2] == 2'b00) else $error("pair");
    chk_hold_len: assert property (
        $rose(pair_off_out[0]) |-> ##HOLD_M1 pair_off_out[0] ##1
        !pair_off_out[0]) else $error("hold length");
    chk_decay_mix: assert property (
        $rose(pair_off_out[0]) |-> low_side_on_out[1:0] == 2'b00 ##FAST_CYC
        low_side_on_out[1:0] == 2'b11) else $error("decay order");
    chk_mask_time: assert property (
        $fell(pair_off_out[0]) |-> !pair_off_out[0] [*2]) else $error("mask");
endmodule // hbd_chopper_checker
bind hbd_half_bridge_drive_and_chopper hbd_chopper_checker #(
    .HOLD_CYC(HOLD_CYC), .MASK_CYC(MASK_CYC)) u_chk (.clk_in, .rstn_in,
    .ctl_a_sel_in, .low_power_request_n_in, .current_halving_sel_in,
    .chop_ref_half_out, .high_side_on_out, .low_side_on_out, .pair_off_out);

// >>> verif/hbd_host_model.sv
// host controller model driving the control pins
`timescale 1ns/100ps
module hbd_host_model (
    // clock and bench command
    input wire logic clk_in,
    input wire logic [3:0] cmd_in,
    // control pins a to d
    output logic [3:0] ctl_out
);
    // pins move only off the sampling edge
    always @(negedge clk_in) ctl_out <= cmd_in;
endmodule // hbd_host_model

// >>> verif/hbd_half_bridge_drive_and_chopper_tb.sv
// self-checking bench for the half-bridge drive and chopper
`timescale 1ns/100ps
module hbd_half_bridge_drive_and_chopper_tb;
    logic clk = 0, rstn = 0, slp_n = 0, hv = 0, t_ab = 0, t_cd = 0, ref_h;
    logic [3:0] cmd = 0, ctl, hs, ls, m;
    logic [1:0] poff;
    int mismatches = 0, n_tests = 0, seed = 32'hac20b3ef, i, w;
    hbd_host_model u_hbd_host_model (.clk_in(clk), .cmd_in(cmd), .ctl_out(ctl));
    hbd_half_bridge_drive_and_chopper #(.HOLD_CYC(8), .MASK_CYC(2))
        u_hbd_half_bridge_drive_and_chopper (.clk_in(clk), .rstn_in(rstn),
        .ctl_a_sel_in(ctl[0]), .ctl_b_sel_in(ctl[1]), .ctl_c_sel_in(ctl[2]),
        .ctl_d_sel_in(ctl[3]), .low_power_request_n_in(slp_n),
        .current_halving_sel_in(hv), .sense_trip_ab_in(t_ab),
        .sense_trip_cd_in(t_cd), .chop_ref_half_out(ref_h),
        .high_side_on_out(hs), .low_side_on_out(ls), .pair_off_out(poff));
    // reference model: three pin stages and an agree stage, then
    // per pair 0 mask, 1 sense, 2 fast, 3 slow
    localparam int M_HOLD = 8;
    localparam int M_MASK = 2;
    localparam int M_FAST = M_HOLD * 25 / 100;
    int mq[$];
    int mpin = 0, agree, k;
    int mph[2], mtm[2];
    logic [3:0] e_hs = 0, e_ls = 0;
    logic [1:0] e_off = 0;
    logic e_ref = 0;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mq.delete();
            mpin = 0;
            e_hs = 0;
            e_ls = 0;
            e_off = 0;
            e_ref = 0;
            for (k = 0; k < 3; k++) begin
                mq.push_back(0);
            end
            for (k = 0; k < 2; k++) begin
                mph[k] = 0;
                mtm[k] = 0;
            end
        end else begin
            e_ref = mpin[5];
            for (k = 0; k < 4; k++) begin
                e_hs[k] = mpin[4] && mph[k / 2] < 2 && mpin[k];
                e_ls[k] = mpin[4] && (mph[k / 2] == 3 ||
                          (mph[k / 2] < 2 && !mpin[k]));
            end
            for (k = 0; k < 2; k++) begin
                e_off[k] = mpin[4] && mph[k] >= 2;
                if (!mpin[4]) begin
                    mph[k] = 0;
                    mtm[k] = 0;
                end else if (mph[k] == 0 && mtm[k] == M_MASK - 1) begin
                    mph[k] = 1;
                    mtm[k] = 0;
                end else if (mph[k] == 1) begin
                    if (mpin[6 + k]) begin
                        mph[k] = 2;
                        mtm[k] = 0;
                    end
                end else if (mph[k] == 3 && mtm[k] == M_HOLD - 1) begin
                    mph[k] = 0;
                    mtm[k] = 0;
                end else begin
                    mph[k] = (mph[k] == 2 && mtm[k] == M_FAST - 1) ? 3 : mph[k];
                    mtm[k]++;
                end
            end
            agree = ~(mq[1] ^ mq[2]) & 32'h0000_00ff;
            mpin = (mpin & ~agree) | (mq[2] & agree);
            void'(mq.pop_back());
            mq.push_front({t_cd, t_ab, hv, slp_n, ctl});
        end
    end
    // every output against the model on each falling edge
    always @(negedge clk) begin
        if (rstn) begin
            n_tests++;
            if ({ref_h, hs, ls, poff} !== {e_ref, e_hs, e_ls, e_off}) begin
                mismatches++;
                $display("mismatch at %0t: model %b %b %b", $time, e_hs,
                         e_ls, e_off);
            end
        end
    end
    // compare reference with hv and gates with the given eh and el
    task automatic chk(input logic [3:0] eh, input logic [3:0] el);
        n_tests++;
        if ({ref_h, hs, ls} !== {hv, eh, el}) begin
            mismatches++;
            $display("mismatch at %0t: gates %b %b", $time, hs, ls);
        end
    endtask
    task automatic final_report;
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial forever #5 clk = ~clk;
    // watchdog
    initial begin
        repeat (2000) @(posedge clk);
        mismatches++;
        final_report();
    end
    // sense nodes stay low unless a trip is wanted
    initial begin
        repeat (2) @(negedge clk);
        rstn = 1;
        repeat (8) @(negedge clk);
        chk(4'h0, 4'h0);
        slp_n = 1;
        for (i = 0; i < 12; i++) begin
            cmd = 4'($random(seed));
            hv = cmd[0] ^ cmd[3];
            repeat (8) @(negedge clk);
            chk(ctl, ~ctl);
        end
        for (i = 0; i < 2; i++) begin
            m = i ? 4'b1100 : 4'b0011;
            if (i == 0) t_ab = 1;
            else t_cd = 1;
            repeat (2) @(negedge clk);
            t_ab = 0;
            t_cd = 0;
            for (w = 0; w < 20 && poff[i] !== 1'b1; w++) @(negedge clk);
            chk(ctl & ~m, ~ctl & ~m);
            repeat (2) @(negedge clk);
            chk(ctl & ~m, (~ctl & ~m) | m);
            for (w = 0; w < 20 && poff[i] !== 1'b0; w++) @(negedge clk);
            chk(ctl, ~ctl);
        end
        slp_n = 0;
        repeat (8) @(negedge clk);
        chk(4'h0, 4'h0);
        final_report();
    end
endmodule // hbd_half_bridge_drive_and_chopper_tb
